// [ebst_sync.sv]
package ebst_pkg;
    // Region control setting layout
    localparam int          CTRL_W      = 9;
    localparam int          WAIT_LSB    = 0;
    localparam int          WAIT_W      = 4;
    localparam int          PORT_LSB    = 4;
    localparam int          BURST_BIT   = 6;
    localparam int          AUTO_BIT    = 7;
    localparam int          VALID_BIT   = 8;
    // Address compare covers the upper half of the address
    localparam int          MATCH_LSB   = 16;
    localparam int          MATCH_W     = 16;
    localparam int          NUM_CS      = 8;
    localparam int          NUM_DRAM    = 2;
    localparam int          IRQ_W       = 3;
    // Transfer size code
    localparam logic [1:0]  SIZE_LONG   = 2'h0;
    localparam logic [1:0]  SIZE_BYTE   = 2'h1;
    localparam logic [1:0]  SIZE_WORD   = 2'h2;
    localparam logic [1:0]  SIZE_LINE   = 2'h3;
    // Port width code
    localparam logic [1:0]  PORT_32     = 2'h0;
    localparam logic [1:0]  PORT_8      = 2'h1;
    localparam logic [1:0]  PORT_16     = 2'h2;
    // Byte counts
    localparam logic [4:0]  BYTES_1     = 5'h01;
    localparam logic [4:0]  BYTES_2     = 5'h02;
    localparam logic [4:0]  BYTES_4     = 5'h04;
    localparam logic [4:0]  BYTES_16    = 5'h10;
    // Region index: 0-7 chip selects, 8-9 DRAM banks, 10 default memory
    localparam logic [3:0]  REG_DRAM0   = 4'h8;
    localparam logic [3:0]  REG_DEFAULT = 4'hA;
    // Reset values
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
endpackage : ebst_pkg

`timescale 1ns/10ps
module ebst_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk, // Bus clock
    input  wire logic         reset,    // Asynchronous reset, active high
    input  wire logic         clk_en,   // Freezes the stages while low
    input  wire logic [W-1:0] d,        // Asynchronous input
    output logic      [W-1:0] q         // Synchronised level
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_q <= '1;
            q      <= '1;
        end else if (clk_en) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : ebst_sync

// [ebst_bus.sv]
// Function
// - Bus error acknowledge aborts the current cycle immediately.
// - Error acknowledge wins over either transfer acknowledge in the same cycle.
// - Error acknowledge one clock after async acknowledge is still honoured.
// - Error acknowledge is ignored during DRAM accesses.
// - Double bus fault halts the bus until reset.
// - Bus signals use the rising edge; DRAM strobes the falling edge.
// - Interrupt level, reset input and async acknowledge are synchronised first.
// - Row strobes change on falling edges; column strobes assert on falling edges.
// - Driven transfer acknowledge is negated one clock before release.
// - Cycle length comes from slave acknowledge or programmed wait states.
// - Chip selects 0-7, then DRAM 0-1, lowest match wins, else default.
// - Default memory transfers assert no chip select or DRAM strobe.
// - Port width is taken from the matched region at cycle start.
// - Operand bytes run msb byte 0 to lsb byte 3.
// - Lsb operand byte goes to lanes 7:0, 23:16 or 31:24 by port.
// - Burst keeps the size code at operand size across narrower beats.
// - Size code follows operand with bursting, port-limited when inhibited.
// - Address bits 1:0 give byte offset and steer the data multiplexer on 32-bit ports; 16-bit uses bit 0 only, 8-bit neither.
// - Size code 00 longword, 01 byte, 10 word, 11 line.
`timescale 1ns/10ps
module ebst_bus
    import ebst_pkg::*;
(
    input  wire logic                               core_clk,               // Bus clock
    input  wire logic                               reset,                  // Async reset
    input  wire logic                               clk_en,                 // Clock enable
    input  wire logic                               req_valid,              // Start a transfer
    input  wire logic                               req_write,              // 1 write, 0 read
    input  wire logic [1:0]                         req_size,               // Operand size code
    input  wire logic [31:0]                        req_addr,               // Operand address
    input  wire logic [31:0]                        req_wdata,              // Operand, byte 0 on top
    input  wire logic                               req_fault_fetch,        // Exception fetch
    input  wire logic [31:0]                        data_in,                // Bus data lanes
    input  wire logic                               bus_error_ack_n,        // Slave error
    input  wire logic                               sync_done_ack_n,        // Sync ack
    input  wire logic                               async_done_ack_n,       // Async ack
    input  wire logic [IRQ_W-1:0]                   irq_priority_level,     // Raw levels
    input  wire logic                               reset_input,            // Raw reset pin
    input  wire logic                               ext_ack_req,            // Ack ext master
    input  wire logic [NUM_CS-1:0][MATCH_W-1:0]     select_base_address,    // CS bases
    input  wire logic [NUM_CS-1:0][MATCH_W-1:0]     select_address_mask,    // CS masks
    input  wire logic [NUM_CS-1:0][CTRL_W-1:0]      select_control_setting, // CS control
    input  wire logic [NUM_DRAM-1:0][MATCH_W-1:0]   dram_base_address,      // DRAM bases
    input  wire logic [NUM_DRAM-1:0][MATCH_W-1:0]   dram_address_mask,      // DRAM masks
    input  wire logic [NUM_DRAM-1:0][CTRL_W-1:0]    dram_control_setting,   // DRAM control
    input  wire logic [NUM_DRAM-1:0][WAIT_W-1:0]    dram_timing_setting,    // DRAM waits
    input  wire logic [CTRL_W-1:0]                  default_mem_control,    // Default ctrl
    output logic      [31:0]                        bus_addr_q,             // Address
    output logic                                    xfer_start_n_q,         // Transfer start
    output logic                                    read_write_q,           // 1 read
    output logic      [1:0]                         xfer_width_code_q,      // Size code
    output logic      [31:0]                        data_out_q,             // Write lanes
    output logic                                    data_oe_n_q,            // Low drives data
    output logic      [NUM_CS-1:0]                  chip_select_n_q,        // Chip selects
    output logic      [NUM_DRAM-1:0]                ras_n_q,                // Row strobes
    output logic      [3:0]                         cas_n_q,                // Column strobes
    output logic                                    sync_ack_out_n_q,       // Driven ack
    output logic                                    sync_ack_oe_n_q,        // Low drives ack
    output logic                                    busy_q,                 // Transfer open
    output logic                                    done_q,                 // Success pulse
    output logic                                    error_q,                // Error pulse
    output logic      [31:0]                        rd_data_q,              // Read operand
    output logic                                    halted_q,               // Halted
    output logic      [IRQ_W-1:0]                   irq_level_sync_q,       // Sync levels
    output logic                                    reset_input_sync_q      // Sync reset pin
);
    typedef enum {ST_IDLE, ST_ADDR, ST_WAIT, ST_LATE, ST_HALT} ebst_state_t;

    ebst_state_t       state_q;
    logic [3:0]        region_q;
    logic [1:0]        port_q;
    logic              burst_q;
    logic              auto_q;
    logic [WAIT_W-1:0] wait_q;
    logic [WAIT_W-1:0] wait_load_q;
    logic [1:0]        size_q;
    logic              write_q;
    logic              fetch_q;
    logic [4:0]        done_bytes_q;
    logic [31:0]       wdata_q;
    logic [1:0]        ext_phase_q;
    logic              async_ack_n;

    // Asynchronous inputs pass two stages before any use
    ebst_sync #(.W(IRQ_W + 2)) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .d        ({irq_priority_level, reset_input, async_done_ack_n}),
        .q        ({irq_level_sync_q, reset_input_sync_q, async_ack_n})
    );

    logic [3:0]        hit_region;
    logic [CTRL_W-1:0] hit_ctrl;
    logic [WAIT_W-1:0] hit_wait;
    logic [MATCH_W-1:0] addr_hi;
    assign addr_hi = req_addr[MATCH_LSB +: MATCH_W];

    always_comb begin
        hit_region = REG_DEFAULT;
        hit_ctrl   = default_mem_control;
        hit_wait   = default_mem_control[WAIT_LSB +: WAIT_W];
        for (int i = NUM_DRAM - 1; i >= 0; i--) begin
            if (dram_control_setting[i][VALID_BIT] &&
                (((addr_hi ^ dram_base_address[i]) & ~dram_address_mask[i]) == '0)) begin
                hit_region = REG_DRAM0 + 4'(i);
                hit_ctrl   = dram_control_setting[i];
                hit_wait   = dram_timing_setting[i];
            end
        end
        for (int i = NUM_CS - 1; i >= 0; i--) begin
            if (select_control_setting[i][VALID_BIT] &&
                (((addr_hi ^ select_base_address[i]) & ~select_address_mask[i]) == '0)) begin
                hit_region = 4'(i);
                hit_ctrl   = select_control_setting[i];
                hit_wait   = select_control_setting[i][WAIT_LSB +: WAIT_W];
            end
        end
    end

    logic [4:0] op_bytes;
    logic [4:0] port_bytes;
    logic [4:0] beat_bytes;
    logic [1:0] lane_start;
    logic [1:0] op_first;
    logic       is_dram;
    logic       last_beat;
    logic [1:0] size_code;

    assign op_bytes   = (size_q == SIZE_BYTE) ? BYTES_1 :
                        (size_q == SIZE_WORD) ? BYTES_2 :
                        (size_q == SIZE_LONG) ? BYTES_4 : BYTES_16;
    assign port_bytes = (port_q == PORT_8)  ? BYTES_1 :
                        (port_q == PORT_16) ? BYTES_2 : BYTES_4;
    assign beat_bytes = (op_bytes < port_bytes) ? op_bytes : port_bytes;
    assign is_dram    = (region_q == REG_DRAM0) || (region_q == REG_DRAM0 + 4'h1);
    assign last_beat  = (done_bytes_q + beat_bytes) >= op_bytes;
    // Offset steers the first lane used on 32- and 16-bit ports; 8-bit always starts at lane 0
    assign lane_start = (port_q == PORT_32) ? bus_addr_q[1:0] :
                        (port_q == PORT_16) ? {1'b0, bus_addr_q[0]} : 2'h0;
    // First operand byte of this beat; a byte sits at 3, a word at 2
    assign op_first   = 2'(((op_bytes > BYTES_4) ? BYTES_4 : op_bytes) == BYTES_4 ?
                           done_bytes_q :
                           (BYTES_4 - op_bytes + done_bytes_q));

    // Size code: constant operand size with bursting, port-limited otherwise
    assign size_code  = burst_q ? size_q :
                        (port_q == PORT_8)  ? SIZE_BYTE :
                        (port_q == PORT_16 && (size_q == SIZE_LONG || size_q == SIZE_LINE)) ?
                            SIZE_WORD :
                        (port_q == PORT_32 && size_q == SIZE_LINE) ? SIZE_LONG : size_q;

    logic [31:0] wr_lanes;
    logic [3:0]  lane_on;
    logic [31:0] rd_next;

    always_comb begin
        logic [2:0] m;
        logic [1:0] idx;
        m        = 3'h0;
        idx      = 2'h0;
        wr_lanes = '0;
        lane_on  = '0;
        rd_next  = rd_data_q;
        for (int l = 0; l < 4; l++) begin
            m   = 3'(l) - {1'b0, lane_start};
            idx = op_first + m[1:0];
            if ({2'b00, m} < beat_bytes) begin
                lane_on[l]                 = 1'b1;
                wr_lanes[31 - 8*l -: 8]    = wdata_q[31 - 8*idx -: 8];
                rd_next[31 - 8*idx -: 8]   = data_in[31 - 8*l -: 8];
            end
        end
    end

    logic bus_err;
    logic wait_over;
    logic beat_ok;
    assign bus_err   = !bus_error_ack_n && !is_dram;
    assign wait_over = (wait_q == '0);
    assign beat_ok   = is_dram ? wait_over :
                       (!sync_done_ack_n || (auto_q && wait_over));

    // Cycle sequencer
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q      <= ST_IDLE;
            region_q     <= REG_DEFAULT;
            port_q       <= PORT_32;
            burst_q      <= 1'b0;
            auto_q       <= 1'b0;
            wait_q       <= '0;
            wait_load_q  <= '0;
            size_q       <= SIZE_LONG;
            write_q      <= 1'b0;
            fetch_q      <= 1'b0;
            done_bytes_q <= '0;
            wdata_q      <= RST_WORD;
            bus_addr_q   <= RST_WORD;
            rd_data_q    <= RST_WORD;
            done_q       <= 1'b0;
            error_q      <= 1'b0;
        end else if (clk_en) begin
            done_q  <= 1'b0;
            error_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        region_q     <= hit_region;
                        port_q       <= hit_ctrl[PORT_LSB +: 2];
                        burst_q      <= hit_ctrl[BURST_BIT];
                        auto_q       <= hit_ctrl[AUTO_BIT];
                        wait_load_q  <= hit_wait;
                        size_q       <= req_size;
                        write_q      <= req_write;
                        fetch_q      <= req_fault_fetch;
                        wdata_q      <= req_wdata;
                        bus_addr_q   <= req_addr;
                        done_bytes_q <= '0;
                        state_q      <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    wait_q  <= wait_load_q;
                    state_q <= ST_WAIT;
                end
                ST_WAIT, ST_LATE: begin
                    if (!wait_over) begin
                        wait_q <= wait_q - 1'b1;
                    end
                    if (bus_err) begin
                        if (fetch_q) begin
                            state_q <= ST_HALT;
                        end else begin
                            error_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end else if (beat_ok || state_q == ST_LATE) begin
                        if (!write_q) begin
                            rd_data_q <= rd_next;
                        end
                        done_bytes_q <= done_bytes_q + beat_bytes;
                        bus_addr_q   <= bus_addr_q + {27'h000_0000, beat_bytes};
                        if (last_beat) begin
                            done_q  <= 1'b1;
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_ADDR;
                        end
                    end else if (!async_ack_n && !is_dram) begin
                        // Hold one clock so a late error still wins
                        state_q <= ST_LATE;
                    end
                end
                ST_HALT: begin
                    state_q <= ST_HALT;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Rising-edge bus outputs
    logic first_beat;
    logic cycle_open;
    assign first_beat = (done_bytes_q == '0);
    assign cycle_open = (state_q == ST_ADDR) || (state_q == ST_WAIT) || (state_q == ST_LATE);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            xfer_start_n_q    <= 1'b1;
            read_write_q      <= 1'b1;
            xfer_width_code_q <= SIZE_LONG;
            data_out_q        <= RST_WORD;
            data_oe_n_q       <= 1'b1;
            chip_select_n_q   <= '1;
            busy_q            <= 1'b0;
            halted_q          <= 1'b0;
        end else if (clk_en) begin
            // Burst beats after the first carry no new start
            xfer_start_n_q    <= !((state_q == ST_ADDR) && (first_beat || !burst_q));
            read_write_q      <= !(cycle_open && write_q);
            xfer_width_code_q <= size_code;
            data_out_q        <= wr_lanes;
            data_oe_n_q       <= !(cycle_open && write_q);
            busy_q            <= (state_q != ST_IDLE) || req_valid;
            halted_q          <= (state_q == ST_HALT);
            for (int i = 0; i < NUM_CS; i++) begin
                chip_select_n_q[i] <= !(cycle_open && region_q == 4'(i));
            end
        end
    end

    // DRAM strobes launch on the falling edge
    always_ff @(negedge core_clk or posedge reset) begin
        if (reset) begin
            ras_n_q <= '1;
            cas_n_q <= '1;
        end else if (clk_en) begin
            for (int b = 0; b < NUM_DRAM; b++) begin
                ras_n_q[b] <= !(cycle_open && region_q == REG_DRAM0 + 4'(b));
            end
            for (int l = 0; l < 4; l++) begin
                cas_n_q[l] <= !((state_q == ST_WAIT) && is_dram && lane_on[l]);
            end
        end
    end

    // External master acknowledge: assert, negate one clock, release
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ext_phase_q      <= 2'h0;
            sync_ack_out_n_q <= 1'b1;
            sync_ack_oe_n_q  <= 1'b1;
        end else if (clk_en) begin
            case (ext_phase_q)
                2'h0: begin
                    sync_ack_oe_n_q  <= 1'b1;
                    sync_ack_out_n_q <= 1'b1;
                    if (ext_ack_req) begin
                        sync_ack_out_n_q <= 1'b0;
                        sync_ack_oe_n_q  <= 1'b0;
                        ext_phase_q      <= 2'h1;
                    end
                end
                2'h1: begin
                    sync_ack_out_n_q <= 1'b1;
                    sync_ack_oe_n_q  <= 1'b0;
                    ext_phase_q      <= 2'h2;
                end
                default: begin
                    sync_ack_out_n_q <= 1'b1;
                    sync_ack_oe_n_q  <= 1'b1;
                    ext_phase_q      <= 2'h0;
                end
            endcase
        end
    end
endmodule : ebst_bus

// [ebst_bus_chk.sv]
`timescale 1ns/10ps
module ebst_bus_chk
    import ebst_pkg::*;
(
    input wire logic             core_clk,           // Clock
    input wire logic             reset,              // Reset
    input wire logic             bus_error_ack_n,    // Slave error
    input wire logic             req_fault_fetch,    // Exception fetch
    input wire logic [IRQ_W-1:0] irq_priority_level, // Raw levels
    input wire logic             reset_input,        // Raw reset pin
    input wire logic [1:0]       ras_n_q,            // Row strobes
    input wire logic [3:0]       cas_n_q,            // Column strobes
    input wire logic             sync_ack_out_n_q,   // Driven ack
    input wire logic             sync_ack_oe_n_q,    // Ack enable
    input wire logic             busy_q,             // Transfer open
    input wire logic             done_q,             // Success
    input wire logic             error_q,            // Error
    input wire logic             halted_q,           // Halted
    input wire logic [IRQ_W-1:0] irq_level_sync_q,   // Sync levels
    input wire logic             reset_input_sync_q  // Sync reset pin
);
    logic [1:0] ras_pos_q;
    logic [3:0] cas_pos_q;
    wire        strobe_idle = &ras_n_q && &cas_n_q;
    // Strobe levels as they stood before each rising edge
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ras_pos_q <= 2'h3;
            cas_pos_q <= 4'hf;
        end else begin
            ras_pos_q <= ras_n_q;
            cas_pos_q <= cas_n_q;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_ack_low;
        !sync_ack_out_n_q && !sync_ack_oe_n_q;
    endsequence
    sequence s_ack_release;
        sync_ack_out_n_q && !sync_ack_oe_n_q ##1 sync_ack_oe_n_q;
    endsequence
    err_wins_a: assert property (busy_q && !bus_error_ack_n && !req_fault_fetch && strobe_idle
        |=> error_q && !done_q) else $error("error ack not honoured");
    dram_err_a: assert property (busy_q && !strobe_idle |=> !error_q)
        else $error("error during dram");
    halt_entry_a: assert property (busy_q && !bus_error_ack_n && req_fault_fetch && strobe_idle
        |-> ##2 halted_q) else $error("double fault did not halt");
    halt_hold_a: assert property (halted_q |=> halted_q) else $error("halt left without reset");
    sync_delay_a: assert property (!$past(reset) && !$past(reset, 2)
        |-> {irq_level_sync_q, reset_input_sync_q} == $past({irq_priority_level, reset_input}, 2))
        else $error("sync latency wrong");
    ack_release_a: assert property ($fell(sync_ack_oe_n_q) |-> s_ack_low ##1 s_ack_release)
        else $error("ack not negated before release");
    ras_edge_a: assert property (@(negedge core_clk) ras_n_q == ras_pos_q)
        else $error("row strobe on rising edge");
    cas_edge_a: assert property (@(negedge core_clk) (~cas_n_q & cas_pos_q) == 4'h0)
        else $error("cas asserted on rising edge");
endmodule : ebst_bus_chk
bind ebst_bus ebst_bus_chk u_chk (.*);

// [ebst_slave.sv]
`timescale 1ns/10ps
module ebst_slave (
    input  wire logic        core_clk,         // Clock
    input  wire logic        xfer_start_n,     // Transfer start
    input  wire logic [2:0]  mode,             // 0 ack 1 err 2 both 3 async 4 async+err
    input  wire logic [3:0]  dly,              // Wait before answering
    input  wire logic [31:0] rdat,             // Read value
    output logic      [31:0] data_in,          // Data lanes
    output logic             sync_done_ack_n,  // Sync ack
    output logic             async_done_ack_n, // Async ack
    output logic             bus_error_ack_n   // Error
);
    logic        pend_q = 1'b0;
    logic        ah_q   = 1'b0;
    logic [3:0]  cnt_q  = 4'h0;
    logic [31:0] last_q = 32'h0000_0000;
    wire         act    = !xfer_start_n || pend_q;
    wire         hit    = act && cnt_q == dly;
    always @(posedge core_clk) begin
        pend_q <= act && !hit;
        cnt_q  <= (act && !hit) ? cnt_q + 4'h1 : 4'h0;
        ah_q   <= hit;
        last_q <= data_in;
    end
    // Async ack held two cycles so the synchroniser can catch it
    assign sync_done_ack_n  = !(hit && (mode == 3'h0 || mode == 3'h2));
    assign async_done_ack_n = !((hit || ah_q) && mode >= 3'h3);
    assign bus_error_ack_n  = !((hit && (mode == 3'h1 || mode == 3'h2)) || (ah_q && mode == 3'h4));
    assign data_in          = (hit || ah_q) ? rdat : ~last_q;
endmodule : ebst_slave

// [test_external_bus_sizing_termination.sv]
`timescale 1ns/10ps
module test_external_bus_sizing_termination
    import ebst_pkg::*;
;
    logic core_clk, reset, clk_en, req_valid, req_write, req_fault_fetch, reset_input, ext_ack_req;
    logic bus_error_ack_n, sync_done_ack_n, async_done_ack_n, xfer_start_n_q, read_write_q;
    logic data_oe_n_q, sync_ack_out_n_q, sync_ack_oe_n_q, busy_q, done_q, error_q, halted_q;
    logic reset_input_sync_q;
    logic [1:0]  req_size, xfer_width_code_q, ras_n_q;
    logic [31:0] req_addr, req_wdata, data_in, rdat, bus_addr_q, data_out_q, rd_data_q, e, m;
    logic [IRQ_W-1:0] irq_priority_level, irq_level_sync_q;
    logic [NUM_CS-1:0][MATCH_W-1:0] select_base_address, select_address_mask;
    logic [NUM_CS-1:0][CTRL_W-1:0]  select_control_setting;
    logic [NUM_DRAM-1:0][MATCH_W-1:0] dram_base_address, dram_address_mask;
    logic [NUM_DRAM-1:0][CTRL_W-1:0]  dram_control_setting;
    logic [NUM_DRAM-1:0][WAIT_W-1:0]  dram_timing_setting;
    logic [CTRL_W-1:0] default_mem_control;
    logic [NUM_CS-1:0] chip_select_n_q;
    logic [3:0]  cas_n_q, dly;
    logic [2:0]  mode;
    logic [31:0] dq[$];
    logic [1:0]  zq[$];
    logic [9:0]  cq[$];
    logic [1:0]  pc[3] = '{PORT_32, PORT_16, PORT_8};
    logic [1:0]  zc[3] = '{SIZE_LONG, SIZE_WORD, SIZE_BYTE};
    int          fails, tests_run, cyc;
    integer      seed = 32'he3d8_60c6;
    ebst_bus DUT (.*);
    ebst_slave u_slave (.core_clk, .xfer_start_n(xfer_start_n_q), .mode, .dly, .rdat, .data_in,
        .sync_done_ack_n, .async_done_ack_n, .bus_error_ack_n);
    task automatic final_report;
        if (fails == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [1:0] sz, input logic [31:0] a, input logic ff);
        int n;
        dq.delete();
        zq.delete();
        cq.delete();
        {req_write, req_size, req_addr, req_fault_fetch} = {w, sz, a, ff};
        req_wdata = $random(seed);
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        for (n = 0; n < 300 && done_q !== 1'b1 && error_q !== 1'b1 && halted_q !== 1'b1; n++)
            @(negedge core_clk);
    endtask : xfer
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(negedge core_clk) {irq_priority_level, reset_input} <= 4'($random(seed));
    // Beat log
    always @(posedge core_clk) begin
        if (xfer_start_n_q === 1'b0) begin
            dq.push_back(data_out_q);
            zq.push_back(xfer_width_code_q);
            cq.push_back({ras_n_q, chip_select_n_q});
        end
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        {reset, clk_en, req_valid, ext_ack_req, mode, dly, rdat} = {3'h6, 1'b0, 39'h0};
        {req_write, req_size, req_addr, req_wdata, req_fault_fetch} = '0;
        {select_base_address, select_address_mask, select_control_setting} = '0;
        select_base_address[0] = 16'h1000;
        select_base_address[1] = 16'h1000;
        select_control_setting[1] = 9'h100;
        {dram_base_address, dram_address_mask} = {16'h0000, 16'h2000, 32'h0000_0000};
        {dram_control_setting, dram_timing_setting} = {9'h000, 9'h100, 8'h02};
        default_mem_control = 9'h100;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        for (int p = 0; p < 3; p++) begin
            select_control_setting[0] = {3'h4, pc[p], 4'h0};
            m = 32'hFFFF_FFFF >> (32 - (32 >> p));
            xfer(1'b1, SIZE_LONG, 32'h1000_0000, 1'b0);
            chk("beats", dq.size(), 1 << p);
            for (int k = 0; k < dq.size(); k++) begin
                chk("size", zq[k], zc[p]);
                chk("region", cq[k], 10'h3fe);
                chk("lanes", (dq[k] >> (32 - (32 >> p))) & m,
                    (req_wdata >> (32 - (32 >> p) * (k + 1))) & m);
            end
            rdat = $random(seed);
            e = 32'h0000_0000;
            repeat (1 << p) e = (e << (32 >> p)) | (rdat >> (32 - (32 >> p)));
            xfer(1'b0, SIZE_LONG, 32'h1000_0000, 1'b0);
            chk("rdata", rd_data_q, e);
        end
        select_control_setting[0] = 9'h100;
        for (int o = 0; o < 4; o++) begin
            xfer(1'b1, SIZE_BYTE, 32'h1000_0000 + o, 1'b0);
            chk("bsize", zq[0], SIZE_BYTE);
            chk("blane", (dq[0] >> (24 - 8 * o)) & 8'hff, req_wdata[7:0]);
        end
        for (int md = 0; md < 5; md++) begin
            {mode, dly} = {3'(md), 4'(md)};
            xfer(1'b1, SIZE_LONG, 32'h1000_0000, 1'b0);
            chk("error", {done_q, error_q}, (md == 0 || md == 3) ? 2'b10 : 2'b01);
        end
        {mode, dly} = {3'h1, 4'h1};
        xfer(1'b0, SIZE_LONG, 32'h2000_0000, 1'b0);
        chk("dram", {done_q, error_q}, 2'b10);
        mode = 3'h0;
        xfer(1'b0, SIZE_LONG, 32'h5000_0000, 1'b0);
        chk("default", cq[0], 10'h3ff);
        ext_ack_req = 1'b1;
        @(negedge core_clk);
        ext_ack_req = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("ackoe", sync_ack_oe_n_q, 1'b1);
        {mode, dly} = {3'h1, 4'h0};
        xfer(1'b0, SIZE_LONG, 32'h1000_0000, 1'b1);
        req_valid = 1'b1;
        repeat (10) @(negedge core_clk);
        chk("halt", {halted_q, done_q}, 2'b10);
        {req_valid, reset, mode} = 5'h08;
        @(negedge core_clk);
        reset = 1'b0;
        chk("unhalt", halted_q, 1'b0);
        xfer(1'b0, SIZE_LONG, 32'h1000_0000, 1'b0);
        chk("resume", done_q, 1'b1);
        final_report();
    end
endmodule : test_external_bus_sizing_termination
